// ==== sasr_cfg.svh ====
// constants for the sar converter serial readout block
`ifndef SASR_CFG_SVH
`define SASR_CFG_SVH
// ************************************************************
// converter geometry
// ************************************************************
`define SASR_RES_BITS      16
`define SASR_BITS_PER_CYC  2
// ************************************************************
// timing, figures in ns, clock at 40 ns
// ************************************************************
`define SASR_CLK_NS        40
`define SASR_TCONV_MIN_NS  278
`define SASR_TCONV_MAX_NS  322
`define SASR_TPOR_NS       20000
// longest time rounds down, least time rounds up
`define SASR_CONV_CYC      (`SASR_TCONV_MAX_NS / `SASR_CLK_NS)
`define SASR_CONV_MIN_CYC  ((`SASR_TCONV_MIN_NS + `SASR_CLK_NS - 1) / `SASR_CLK_NS)
`define SASR_POR_CYC       ((`SASR_TPOR_NS + `SASR_CLK_NS - 1) / `SASR_CLK_NS)
// ************************************************************
// register offsets (byte addresses)
// ************************************************************
`define SASR_OFS_STATUS    8'h00
`define SASR_OFS_RESULT    8'h04
`define SASR_OFS_IRQ_STAT  8'h08
`define SASR_OFS_IRQ_CLR   8'h0C
`define SASR_OFS_IRQ_EN    8'h10
// ************************************************************
// field positions and reset values
// ************************************************************
`define SASR_ST_BUSY       0
`define SASR_ST_CHAIN      1
`define SASR_ST_POWER      2
`define SASR_ST_READY      3
`define SASR_EV_DONE       0
`define SASR_EV_OVERRUN    1
`define SASR_EV_READOUT    2
`define SASR_EV_EARLY      3
`define SASR_EV_W          4
`define SASR_IRQ_EN_RST    4'h0
`define SASR_RESULT_RST    16'h0000
`endif

// ==== sasr_pkg.sv ====
// types shared by the sar converter serial readout block
package sasr_pkg;
  // converter sequencing phases
  typedef enum logic [1:0] {
    SASR_ACQUIRE,
    SASR_CONVERT,
    SASR_LOAD
  } sasr_state_t;
  // latched ahb address phase
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } sasr_aphase_t;
  // synchronised link pins
  typedef struct packed {
    logic convert_start;
    logic sck;
    logic read_enable_or_chain_input;
    logic chain;
  } sasr_pins_t;
endpackage

// ==== sasr_sync.sv ====
// two flip-flop level synchroniser, one bit per lane
module sasr_sync #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         rst_i,
  // asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_reg;  // first stage, read only by second
  logic [W-1:0] sync_reg;  // second stage
  // two stages, nothing taps the first
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end
  assign sync_o = sync_reg;
endmodule

// ==== sasr_top.sv ====
// sar converter control, serial readout and ahb-lite register slave
//
// Decided for this implementation: register access over AHB-Lite and the register offsets.
`include "sasr_cfg.svh"
// Function
// [R1] chain low: shared pin enables serial output
// [R2] chain high: shared pin is chain data
// [R3] convert rising edge wakes, starts conversion
// [R4] busy high during conversion only
// [R5] serial clock rise shifts next bit, msb first
// [R6] result is unsigned straight binary
// [R7] sixteen bit result, 65536 codes
// [R8] sixteen successive approximation bit decisions
// [R9] track between conversions, freeze on edge
// [R10] conversion timed internally, host clock unused
// [R11] auto power down after conversion ends
// [R12] readable result belongs to same conversion
// [R13] result loaded into shift path at end
// [R14] host waits 20 us after power-on
// [R15] host reads after busy falls, before next
module sasr_top
  import sasr_pkg::*;
#(
  parameter int RES_BITS = `SASR_RES_BITS,
  parameter int BPC      = `SASR_BITS_PER_CYC
) (
  // clock and reset
  input  wire logic                clk_sys_i,
  input  wire logic                rst_i,
  // converter pins
  input  wire logic                convert_start_i,
  input  wire logic                chain_select_i,
  input  wire logic                read_enable_or_chain_input_i,
  input  wire logic                sck_i,
  output logic                     busy_o,
  output logic                     sdo_o,
  output logic                     sdo_oe_o,
  // analog front end: tracked input level as a code
  input  wire logic [RES_BITS-1:0] analog_level_i,
  output logic                     power_on_o,
  // ahb-lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic [31:0]              hrdata,
  // interrupt
  output logic                     irq_o
);
  // ************************************************************
  // local constants
  // ************************************************************
  localparam int CONV_CYC = RES_BITS / BPC;         // cycles per conversion
  localparam int CW       = $clog2(RES_BITS + 1);   // bit counter width
  localparam int PW       = $clog2(`SASR_POR_CYC + 1);

  // one approximation step: try the bit, keep it if not above sample
  function automatic logic [RES_BITS-1:0] sasr_decide(
    input logic [RES_BITS-1:0] code,
    input logic [RES_BITS-1:0] sample,
    input logic [CW-1:0]       pos
  );
    logic [RES_BITS-1:0] trial;
    trial = code | (RES_BITS'(1) << pos);
    sasr_decide = (trial <= sample) ? trial : code;
  endfunction

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  sasr_pins_t pins;       // synchronised pins
  sasr_pins_t pins_prev;  // one cycle older, for edges
  logic [3:0] pins_raw;   // raw pins into the synchroniser
  logic [3:0] pins_sync;  // synchroniser output

  assign pins_raw = {convert_start_i, sck_i, read_enable_or_chain_input_i, chain_select_i};

  sasr_sync #(
    .W (4)
  ) sasr_sync_i (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .async_i   (pins_raw),
    .sync_o    (pins_sync)
  );

  assign pins = sasr_pins_t'(pins_sync);

  // edge history
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pins_prev <= '0;
    end else begin
      pins_prev <= pins;
    end
  end

  wire cnv_rise = pins.convert_start & ~pins_prev.convert_start;  // convert edge
  wire sck_rise = pins.sck & ~pins_prev.sck;  // shift edge

  // ************************************************************
  // registers
  // ************************************************************
  sasr_state_t         state_reg;     // sequencer phase
  logic [RES_BITS-1:0] held_reg;      // frozen sample
  logic [RES_BITS-1:0] code_reg;      // approximation in progress
  logic [CW-1:0]       pos_reg;       // bits still to decide, one above the next position
  logic [RES_BITS-1:0] result_reg;    // last finished result
  logic [RES_BITS-1:0] shift_reg;     // serial output path
  logic [CW-1:0]       shcnt_reg;     // bits shifted since load
  logic                busy_reg;      // busy pin
  logic                power_reg;     // analog core powered
  logic                sdo_reg;       // serial data pin
  logic                sdo_oe_reg;    // serial data drive
  logic [PW-1:0]       por_reg;       // power-on settle counter
  logic                early_reg;     // running conversion started early
  logic [`SASR_EV_W-1:0] ev_stat_reg; // sticky events
  logic [`SASR_EV_W-1:0] ev_en_reg;   // event enables
  logic                irq_reg;       // interrupt pin
  sasr_aphase_t        ap_reg;        // latched address phase
  logic [31:0]         rdata_reg;     // read data
  logic                ready_reg;     // hreadyout

  // ************************************************************
  // conversion sequencer
  // ************************************************************
  wire por_done   = (por_reg == PW'(`SASR_POR_CYC));
  wire start_conv = cnv_rise & (state_reg == SASR_ACQUIRE);      // [R3]
  wire overrun    = cnv_rise & (state_reg != SASR_ACQUIRE);
  wire last_step  = (state_reg == SASR_CONVERT) && (pos_reg <= CW'(BPC));  // eighth step

  // two decisions per cycle, msb downward
  wire [RES_BITS-1:0] step1 = sasr_decide(code_reg, held_reg, pos_reg - CW'(1)); // [R8]
  wire [RES_BITS-1:0] step2 = sasr_decide(step1, held_reg, pos_reg - CW'(2));    // [R8]

  // sequencer: acquire, convert in eight cycles, load
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_reg <= SASR_ACQUIRE;
      held_reg  <= '0;
      code_reg  <= '0;
      pos_reg   <= '0;
      early_reg <= 1'b0;
    end else begin
      case (state_reg)
        SASR_ACQUIRE: begin
          if (start_conv) begin
            held_reg  <= analog_level_i;            // [R9]
            code_reg  <= '0;
            pos_reg   <= CW'(RES_BITS);             // [R7]
            early_reg <= ~por_done;                 // [R14]
            state_reg <= SASR_CONVERT;              // [R10]
          end
        end
        SASR_CONVERT: begin
          code_reg <= step2;                        // [R8]
          pos_reg  <= pos_reg - CW'(BPC);
          if (last_step) begin
            state_reg <= SASR_LOAD;
          end
        end
        SASR_LOAD: begin
          state_reg <= SASR_ACQUIRE;                // [R9]
        end
        default: begin
          state_reg <= SASR_ACQUIRE;
        end
      endcase
    end
  end

  // busy and power follow the sequencer
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      busy_reg  <= 1'b0;
      power_reg <= 1'b0;
    end else if (start_conv) begin
      busy_reg  <= 1'b1;                            // [R4]
      power_reg <= 1'b1;                            // [R3]
    end else if (state_reg == SASR_LOAD) begin
      busy_reg  <= 1'b0;                            // [R4]
      power_reg <= 1'b0;                            // [R11]
    end
  end

  // power-on settle counter
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      por_reg <= '0;
    end else if (!por_done) begin
      por_reg <= por_reg + PW'(1);
    end
  end

  // ************************************************************
  // serial output path
  // ************************************************************
  wire load_now   = (state_reg == SASR_LOAD);
  wire chain_in   = pins.chain & pins.read_enable_or_chain_input;      // [R2]
  wire [RES_BITS-1:0] shifted = {shift_reg[RES_BITS-2:0], chain_in};
  wire readout_end = sck_rise & ~load_now & (shcnt_reg == CW'(RES_BITS - 1));
  wire out_en     = pins.chain | ~pins.read_enable_or_chain_input;     // [R1]

  // load at end of conversion, shift on serial clock rise while out_en is high
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      result_reg <= `SASR_RESULT_RST;
      shift_reg  <= '0;
      shcnt_reg  <= '0;
      sdo_reg    <= 1'b0;
    end else if (load_now) begin
      result_reg <= code_reg;                       // [R12]
      shift_reg  <= code_reg;                       // [R13] [R6]
      shcnt_reg  <= '0;
      sdo_reg    <= code_reg[RES_BITS-1];           // [R5]
    end else if (sck_rise & out_en) begin
      shift_reg  <= shifted;                        // [R5]
      sdo_reg    <= shifted[RES_BITS-1];            // [R5]
      if (shcnt_reg != CW'(RES_BITS)) begin
        shcnt_reg <= shcnt_reg + CW'(1);
      end
    end
  end

  // output drive follows mode and enable
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sdo_oe_reg <= 1'b0;
    end else begin
      sdo_oe_reg <= out_en;                         // [R1] [R2]
    end
  end

  // ************************************************************
  // interrupt events
  // ************************************************************
  logic [`SASR_EV_W-1:0] ev_set;
  logic [`SASR_EV_W-1:0] ev_clr;
  assign ev_set = {load_now & early_reg, readout_end & out_en, overrun, load_now};

  // sticky status, set beats clear
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ev_stat_reg <= '0;
      irq_reg     <= 1'b0;
    end else begin
      ev_stat_reg <= (ev_stat_reg & ~ev_clr) | ev_set;
      irq_reg     <= |(((ev_stat_reg & ~ev_clr) | ev_set) & ev_en_reg);
    end
  end

  // ************************************************************
  // ahb-lite slave
  // ************************************************************
  wire take = hsel & htrans[1] & hready;
  wire wr_dp = ap_reg.valid & ap_reg.write;
  wire [7:0] wa = ap_reg.addr;
  assign ev_clr = (wr_dp && wa == `SASR_OFS_IRQ_CLR) ? hwdata[`SASR_EV_W-1:0] : '0;

  wire [31:0] status_word = {28'h000_0000, por_done, power_reg, pins.chain, busy_reg};
  logic [31:0] rd_mux;
  always_comb begin
    case (haddr[7:0])
      `SASR_OFS_STATUS:   rd_mux = status_word;
      `SASR_OFS_RESULT:   rd_mux = {16'h0000, result_reg};
      `SASR_OFS_IRQ_STAT: rd_mux = {28'h000_0000, ev_stat_reg};
      `SASR_OFS_IRQ_EN:   rd_mux = {28'h000_0000, ev_en_reg};
      default:            rd_mux = 32'h0000_0000;
    endcase
  end

  // address phase capture and read data
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ap_reg    <= '0;
      rdata_reg <= 32'h0000_0000;
      ready_reg <= 1'b1;
    end else begin
      if (hready) begin
        ap_reg <= '{valid: take, write: hwrite, addr: haddr[7:0]};
      end
      if (take & ~hwrite) begin
        rdata_reg <= (haddr[31:8] == 24'h00_0000) ? rd_mux : 32'h0000_0000;
      end
      ready_reg <= 1'b1;
    end
  end

  // enable register write
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ev_en_reg <= `SASR_IRQ_EN_RST;
    end else if (wr_dp && wa == `SASR_OFS_IRQ_EN) begin
      ev_en_reg <= hwdata[`SASR_EV_W-1:0];
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign busy_o     = busy_reg;
  assign sdo_o      = sdo_reg;
  assign sdo_oe_o   = sdo_oe_reg;
  assign power_on_o = power_reg;
  assign irq_o      = irq_reg;
  assign hrdata     = rdata_reg;
  assign hreadyout  = ready_reg;
  assign hresp      = 1'b0;
endmodule

// ==== sasr_top_asserts.sv ====
// port-level assertions for the sar converter readout block
module sasr_top_asserts #(
  parameter int RES_BITS = 16,
  parameter int BPC      = 2
) (
  // clock and reset
  input wire logic                clk_sys_i,
  input wire logic                rst_i,
  // converter pins
  input wire logic                convert_start_i,
  input wire logic                chain_select_i,
  input wire logic                read_enable_or_chain_input_i,
  input wire logic                sck_i,
  input wire logic [RES_BITS-1:0] analog_level_i,
  input wire logic                busy_o,
  input wire logic                sdo_o,
  input wire logic                sdo_oe_o,
  input wire logic                power_on_o,
  // bus answer
  input wire logic                hreadyout,
  input wire logic                hresp
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // ************************************************************
  // conversion sequencing
  // ************************************************************
  a_busy_width: assert property ($rose(busy_o) |-> busy_o[*8] ##1 busy_o ##1 !busy_o)
    else $error("busy pulse not nine cycles");
  a_power_track: assert property (power_on_o == busy_o)
    else $error("power not tied to conversion");
  a_conv_start: assert property ($rose(convert_start_i) && !busy_o |-> ##[2:5] $rose(busy_o))
    else $error("convert edge did not start conversion");
  a_busy_cause: assert property ($rose(busy_o) |-> $past(convert_start_i, 3))
    else $error("busy rose without convert");
  a_first_bit: assert property ($fell(busy_o) |-> sdo_o == analog_level_i[RES_BITS-1])
    else $error("msb not loaded at end of conversion");
  // ************************************************************
  // serial output and bus answer
  // ************************************************************
  a_chain_oe: assert property (chain_select_i[*5] |-> sdo_oe_o)
    else $error("chain mode output not driven");
  a_normal_oe: assert property (
    (!chain_select_i && $stable(read_enable_or_chain_input_i))[*5]
    |-> sdo_oe_o == !read_enable_or_chain_input_i)
    else $error("output enable wrong in normal mode");
  a_sdo_quiet: assert property ((!sck_i)[*6] |-> $stable(sdo_o) || $fell(busy_o))
    else $error("sdo moved without a clock rise");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
endmodule
bind sasr_top sasr_top_asserts #(.RES_BITS(RES_BITS), .BPC(BPC)) sasr_top_asserts_i (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .convert_start_i(convert_start_i),
  .chain_select_i(chain_select_i), .read_enable_or_chain_input_i(read_enable_or_chain_input_i),
  .sck_i(sck_i), .analog_level_i(analog_level_i), .busy_o(busy_o), .sdo_o(sdo_o),
  .sdo_oe_o(sdo_oe_o), .power_on_o(power_on_o), .hreadyout(hreadyout), .hresp(hresp));

// ==== sasr_host_model.sv ====
// host model: convert pin, serial clock and the shared enable/chain pin
module sasr_host_model (
  // clock
  input  wire logic clk_sys_i,
  // device outputs
  input  wire logic busy_i,
  input  wire logic sdo_i,
  // device inputs
  output logic      cnv_o,
  output logic      sck_o,
  output logic      rdl_o,
  output logic      chain_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int bad = 0; // waits that ran out
  initial begin
    cnv_o = 1'b0;
    sck_o = 1'b0;
    rdl_o = 1'b1;
    chain_o = 1'b0;
  end
  // select mode and enable level
  task automatic mode(input logic ch, input logic rd);
    chain_o <= ch;
    rdl_o <= rd;
  endtask
  // convert edge, optional second edge while busy, then wait for busy low
  task automatic conv(input bit again);
    int k;
    k = 0;
    @(posedge clk_sys_i) cnv_o <= 1'b1;
    while (!busy_i && k < 20) begin @(posedge clk_sys_i); k++; end
    if (k >= 20) bad++;
    cnv_o <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    cnv_o <= again;
    repeat (2) @(posedge clk_sys_i);
    cnv_o <= 1'b0;
    while (busy_i && k < 40) begin @(posedge clk_sys_i); k++; end
    if (busy_i) bad++;
  endtask
  // clock n bits out, feeding upstream bits msb first in chain mode
  task automatic shift(input int n, input logic [15:0] up, output logic [31:0] got);
    got = '0;
    #7; // keep link edges off the system clock
    for (int i = 0; i < n; i++) begin
      got = {got[30:0], sdo_i};
      if (chain_o) rdl_o = (i < 16) ? up[15-i] : ~rdl_o;
      #140 sck_o = 1'b1;
      #160 sck_o = 1'b0;
      #20;
    end
    if (chain_o) rdl_o = ~rdl_o; // released line shows no stale bit
  endtask
endmodule

// ==== sasr_top_tb.sv ====
// self-checking bench for the sar converter readout block
`include "sasr_cfg.svh"
module sasr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_i, rst_i, hsel, hwrite;
  logic [31:0] haddr, hwdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [15:0] analog, u;
  wire  [31:0] hrdata;
  wire         hready, hreadyout, hresp, busy, sdo, sdo_oe, power, irq, convert_start, sck, rdl, chain;
  int          n_errors = 0;
  int          check_count = 0;
  logic [31:0] seed = 32'h0000_AF3D; // xorshift state
  logic [15:0] exp_q[$];             // expected results in order
  localparam logic [31:0] DN = 32'h0000_0001 << `SASR_EV_DONE;
  localparam logic [31:0] OV = 32'h0000_0001 << `SASR_EV_OVERRUN;
  localparam logic [31:0] RO = 32'h0000_0001 << `SASR_EV_READOUT;
  localparam logic [31:0] EA = 32'h0000_0001 << `SASR_EV_EARLY;
  localparam logic [31:0] RDY = 32'h0000_0001 << `SASR_ST_READY;
  assign hready = hreadyout;
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  sasr_top sasr_top_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .convert_start_i(convert_start),
    .chain_select_i(chain), .read_enable_or_chain_input_i(rdl), .sck_i(sck), .busy_o(busy),
    .sdo_o(sdo), .sdo_oe_o(sdo_oe), .analog_level_i(analog), .power_on_o(power), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq_o(irq));
  sasr_host_model sasr_host_model_i (.clk_sys_i(clk_sys_i), .busy_i(busy), .sdo_i(sdo),
    .cnv_o(convert_start), .sck_o(sck), .rdl_o(rdl), .chain_o(chain));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // one single ahb-lite transfer, waiting on hready in both phases
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_sys_i);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    do begin @(posedge clk_sys_i); k++; end while (!hreadyout && k < 20);
    if (!hreadyout) begin
      n_errors++;
      stop_test();
    end
    htrans <= 2'b00;
    hwdata <= d;
    k = 0;
    do begin @(posedge clk_sys_i); k++; end while (!hreadyout && k < 20);
    q = hrdata;
    if (!hreadyout) begin
      n_errors++;
      stop_test();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask
  // model the conversion result, then start the conversion
  task automatic convert(input logic [15:0] v, input bit again);
    analog <= v;
    exp_q.push_back(v);
    sasr_host_model_i.conv(again);
  endtask
  task automatic readout(input int n, input logic [15:0] up);
    logic [31:0] got;
    sasr_host_model_i.shift(n, up, got);
    chk(got, (n == 32) ? {exp_q[0], up} : {16'h0000, exp_q[0]});
    void'(exp_q.pop_front());
  endtask
  initial begin
    rst_i = 1'b1;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = '0;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = '0;
    analog = '0;
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rd(`SASR_OFS_IRQ_EN, 32'h0000_0000);
    rd(`SASR_OFS_RESULT, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    rd(`SASR_OFS_STATUS, 32'h0000_0000);
    $display("test reset values done");
    sasr_host_model_i.mode(1'b0, 1'b0);
    convert(16'h1234, 1'b0);
    rd(`SASR_OFS_IRQ_STAT, DN | EA);
    readout(16, 16'h0000);
    bus(1'b1, `SASR_OFS_IRQ_CLR, 32'h0000_000F);
    repeat (`SASR_POR_CYC) @(posedge clk_sys_i);
    rd(`SASR_OFS_STATUS, RDY);
    $display("test power-on wait done");
    sasr_host_model_i.mode(1'b0, 1'b0);
    for (int i = 0; i < 6; i++) begin
      u = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : 16'(rnd());
      bus(1'b1, `SASR_OFS_IRQ_CLR, 32'h0000_000F);
      convert(u, i == 3);
      if (i == 2) begin
        sasr_host_model_i.mode(1'b0, 1'b1);
        sasr_host_model_i.shift(4, 16'h0000, q);
        chk(32'(sdo_oe), 32'h0000_0000);
        sasr_host_model_i.mode(1'b0, 1'b0);
      end
      readout(16, 16'h0000);
      rd(`SASR_OFS_RESULT, {16'h0000, u});
      rd(`SASR_OFS_IRQ_STAT, DN | RO | ((i == 3) ? OV : 32'h0000_0000));
    end
    $display("test normal mode done");
    sasr_host_model_i.mode(1'b1, 1'b0);
    repeat (6) @(posedge clk_sys_i);
    convert(16'(rnd()), 1'b0);
    readout(32, 16'(rnd()));
    rd(`SASR_OFS_STATUS, RDY | (32'h0000_0001 << `SASR_ST_CHAIN));
    sasr_host_model_i.mode(1'b0, 1'b0);
    $display("test chain mode done");
    bus(1'b1, `SASR_OFS_IRQ_CLR, 32'h0000_000F);
    bus(1'b1, `SASR_OFS_IRQ_EN, DN);
    rd(`SASR_OFS_IRQ_EN, DN);
    convert(16'(rnd()), 1'b0);
    repeat (2) @(posedge clk_sys_i);
    chk(32'(irq), 32'h0000_0001);
    bus(1'b1, `SASR_OFS_IRQ_EN, 32'h0000_0000);
    repeat (2) @(posedge clk_sys_i);
    chk(32'(irq), 32'h0000_0000);
    bus(1'b1, `SASR_OFS_IRQ_EN, DN);
    repeat (2) @(posedge clk_sys_i);
    chk(32'(irq), 32'h0000_0001);
    bus(1'b1, `SASR_OFS_IRQ_CLR, DN);
    repeat (2) @(posedge clk_sys_i);
    chk(32'(irq), 32'h0000_0000);
    readout(16, 16'h0000);
    $display("test interrupt done");
    n_errors += sasr_host_model_i.bad;
    stop_test();
  end
endmodule
